/* File: logic/bbt_checker.sv */
// Module: block transfer checker for incoming point and settings blocks
module bbt_checker
	import bbt_pkg::*;
#(
	parameter logic [15:0] SET_MAX = SET_MAX_RST,
	parameter logic [7:0]  FW_VER  = FW_VER_RST
)(
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	input  wire logic       rx_valid,
	input  wire bbt_byte_t  rx_byte,
	output logic            rx_ready,
	input  wire logic       blk_start,
	input  wire bbt_kind_t  blk_kind,
	input  wire logic [15:0] point_count_field,
	input  wire logic       echo_on,
	input  wire logic       slot_exists,
	input  wire logic       mem_avail,
	input  wire logic       alloc_req_ack,
	input  wire logic       query_req,
	input  wire logic       src_is_slot,
	input  wire logic       src_exists,
	input  wire logic       corrupt_at_pwrup,
	input  wire logic       ascii_value,
	input  wire logic       ascii_end,
	output bbt_point_t      pt_q,
	output logic            pt_we_q,
	output logic            alloc_q,
	output logic            set_install_q,
	output logic            set_discard_q,
	output logic            load_defaults_q,
	output logic            query_go_q,
	output logic [7:0]      set_byte_q,
	output logic            set_byte_we_q,
	input  wire logic       ev_pop,
	output logic [9:0]      ev_code,
	output logic            ev_valid
);

	//=============================================
	// State
	typedef enum logic [2:0] {S_IDLE, S_MARK, S_CNT_HI, S_CNT_LO, S_VER, S_BODY, S_FILL, S_DROP} bbt_state_t;
	bbt_state_t  st_q;
	bbt_kind_t   kind_q;
	logic [15:0] remain_q, nr_q, idx_q;
	logic [7:0]  sum_q, lo_q;
	logic        half_q, odd_q, bad_q, pw_q;

	wire take       = rx_valid && rx_ready;
	wire last_byte  = take && remain_q == 16'h0001;
	wire early_end  = take && rx_byte.eoi && remain_q != 16'h0001;
	wire [7:0] nsum = sum_q + rx_byte.data;
	wire csum_ok    = nsum == 8'h00; // [RULE12]
	wire pts_kind   = kind_q == BBT_KIND_POINTS;
	assign rx_ready = st_q != S_IDLE && st_q != S_FILL;

	//=============================================
	// Event queue
	logic [9:0]  evq [EVQ_DEPTH];
	logic [3:0]  wp_q, rp_q;
	logic        post;
	logic [9:0]  post_code;
	assign ev_valid = wp_q != rp_q; // [RULE23]
	assign ev_code  = evq[rp_q[2:0]];
	wire ev_full    = wp_q[2:0] == rp_q[2:0] && wp_q[3] != rp_q[3];

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			wp_q <= 4'h0;
			rp_q <= 4'h0;
		end
		else
		begin
			if (post && !ev_full)
			begin
				evq[wp_q[2:0]] <= post_code; // [RULE23]
				wp_q <= wp_q + 4'h1;
			end
			if (ev_pop && ev_valid)
				rp_q <= rp_q + 4'h1;
		end
	end

	//=============================================
	// Block parser
	always_comb
	begin
		post      = 1'b0;
		post_code = 10'h000;
		if (!pw_q && corrupt_at_pwrup)
		begin
			post = 1'b1;
			post_code = EV_CORRUPT; // [RULE18]
		end
		else if (query_req && !src_exists)
		begin
			post = 1'b1;
			post_code = src_is_slot ? EV_NO_SLOT : EV_NO_TRACE; // [RULE1] [RULE2] [RULE10]
		end
		else if (st_q == S_MARK && take && rx_byte.serial && echo_on)
		begin
			post = 1'b1;
			post_code = EV_ECHO_BIN; // [RULE16]
		end
		else if (st_q == S_IDLE && blk_start && blk_kind == BBT_KIND_POINTS && !slot_exists && !mem_avail)
		begin
			post = 1'b1;
			post_code = EV_NO_MEMORY; // [RULE5]
		end
		else if (st_q == S_CNT_LO && take && kind_q == BBT_KIND_SETTINGS && {remain_q[7:0], rx_byte.data} > SET_MAX)
		begin
			post = 1'b1;
			post_code = EV_SET_BIG; // [RULE15]
		end
		else if ((st_q == S_BODY || st_q == S_VER) && early_end)
		begin
			post = 1'b1;
			post_code = pts_kind ? EV_PT_SHORT : EV_SET_SHORT; // [RULE7] [RULE14]
		end
		else if (st_q == S_BODY && last_byte)
		begin
			post = 1'b1;
			if (!csum_ok)
				post_code = pts_kind ? EV_PT_CSUM : EV_SET_CSUM; // [RULE6] [RULE13]
			else if (!pts_kind && bad_q)
				post_code = EV_SET_VER; // [RULE17]
			else if (pts_kind && odd_q)
				post_code = EV_PT_ODD; // [RULE8]
			else if (pts_kind && idx_q > nr_q)
				post_code = EV_BIN_EXCESS; // [RULE3]
			else
				post = 1'b0;
		end
		else if (kind_q == BBT_KIND_ASCII && st_q == S_BODY && ascii_end && idx_q > nr_q)
		begin
			post = 1'b1;
			post_code = EV_ASC_EXCESS; // [RULE4]
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			st_q <= S_IDLE;
			kind_q <= BBT_KIND_POINTS;
			remain_q <= 16'h0000;
			nr_q <= RST_POINT_COUNT_FIELD;
			idx_q <= 16'h0000;
			sum_q <= 8'h00;
			lo_q <= 8'h00;
			half_q <= 1'b0;
			odd_q <= 1'b0;
			bad_q <= 1'b0;
			pw_q <= 1'b0;
			pt_q <= '0;
			pt_we_q <= 1'b0;
			alloc_q <= 1'b0;
			set_install_q <= 1'b0;
			set_discard_q <= 1'b0;
			load_defaults_q <= 1'b0;
			query_go_q <= 1'b0;
			set_byte_q <= 8'h00;
			set_byte_we_q <= 1'b0;
		end
		else
		begin
			pw_q <= 1'b1;
			load_defaults_q <= !pw_q && corrupt_at_pwrup; // [RULE18]
			// Query runs preamble then points only when its source exists
			query_go_q <= query_req && src_exists; // [RULE9]
			pt_we_q <= 1'b0;
			alloc_q <= 1'b0;
			set_install_q <= 1'b0;
			set_discard_q <= 1'b0;
			set_byte_we_q <= 1'b0;
			unique case (st_q)
				S_IDLE:
					if (blk_start)
					begin
						kind_q <= blk_kind;
						nr_q <= point_count_field;
						idx_q <= 16'h0000;
						sum_q <= 8'h00;
						half_q <= 1'b0;
						bad_q <= 1'b0;
						if (blk_kind == BBT_KIND_ASCII)
							st_q <= S_BODY;
						else if (blk_kind == BBT_KIND_POINTS && !slot_exists)
						begin
							alloc_q <= mem_avail; // [RULE5]
							st_q <= mem_avail ? S_MARK : S_DROP;
						end
						else
							st_q <= S_MARK;
					end
				S_MARK:
					if (take)
					begin
						// Echoed serial data cannot carry binary safely
						st_q <= (rx_byte.serial && echo_on) || rx_byte.data != BLOCK_MARK ? S_DROP : S_CNT_HI; // [RULE16]
						set_discard_q <= kind_q == BBT_KIND_SETTINGS && rx_byte.serial && echo_on; // [RULE16]
					end
				S_CNT_HI:
					if (take)
					begin
						remain_q <= {8'h00, rx_byte.data}; // [RULE21]
						sum_q <= rx_byte.data;
						st_q <= S_CNT_LO;
					end
				S_CNT_LO:
					if (take)
					begin
						remain_q <= {remain_q[7:0], rx_byte.data};
						sum_q <= nsum;
						// Count covers the checksum, so its parity flags an odd data byte
						odd_q <= !rx_byte.data[0]; // [RULE8]
						if (kind_q == BBT_KIND_SETTINGS && {remain_q[7:0], rx_byte.data} > SET_MAX)
						begin
							set_discard_q <= 1'b1; // [RULE15]
							st_q <= S_DROP;
						end
						else
							st_q <= kind_q == BBT_KIND_SETTINGS ? S_VER : S_BODY;
					end
				S_VER:
					if (take)
					begin
						remain_q <= remain_q - 16'h0001;
						sum_q <= nsum;
						bad_q <= rx_byte.data != FW_VER; // [RULE17]
						set_byte_q <= rx_byte.data;
						set_byte_we_q <= 1'b1;
						if (early_end)
						begin
							set_discard_q <= 1'b1; // [RULE14]
							st_q <= S_IDLE;
						end
						else
							st_q <= S_BODY;
					end
				S_BODY:
					if (kind_q == BBT_KIND_ASCII)
					begin
						if (ascii_value)
						begin
							if (idx_q < nr_q)
							begin
								pt_q <= '{index: idx_q, value: {lo_q, rx_byte.data}};
								pt_we_q <= 1'b1;
							end
							idx_q <= idx_q + 16'h0001; // [RULE4]
						end
						if (ascii_end)
							st_q <= idx_q < nr_q ? S_FILL : S_IDLE; // [RULE22]
					end
					else if (take)
					begin
						remain_q <= remain_q - 16'h0001;
						sum_q <= nsum;
						if (!pts_kind)
						begin
							set_byte_q <= rx_byte.data;
							set_byte_we_q <= !last_byte; // [RULE20]
							if (early_end)
							begin
								set_discard_q <= 1'b1; // [RULE14]
								st_q <= S_IDLE;
							end
							else if (last_byte)
							begin
								set_install_q <= csum_ok && !bad_q; // [RULE13] [RULE17]
								set_discard_q <= !csum_ok || bad_q;
								st_q <= S_IDLE;
							end
						end
						else if (!last_byte)
						begin
							half_q <= !half_q;
							lo_q <= rx_byte.data;
							if (half_q)
							begin
								// Excess points are counted but never written
								if (idx_q < nr_q)
								begin
									pt_q <= '{index: idx_q, value: {lo_q, rx_byte.data}}; // [RULE21] [RULE3]
									pt_we_q <= 1'b1;
								end
								idx_q <= idx_q + 16'h0001;
							end
							if (early_end)
								st_q <= S_FILL; // [RULE7]
						end
						else
							// Checksum failure still keeps data; only an unpaired byte is lost
							st_q <= idx_q < nr_q ? S_FILL : S_IDLE; // [RULE6] [RULE8] [RULE22]
					end
				S_FILL:
					if (idx_q < nr_q)
					begin
						pt_q <= '{index: idx_q, value: NULL_POINT}; // [RULE22] [RULE7]
						pt_we_q <= 1'b1;
						idx_q <= idx_q + 16'h0001;
					end
					else
						st_q <= S_IDLE;
				S_DROP:
					if (take && rx_byte.eoi)
						st_q <= S_IDLE;
				default:
					st_q <= S_IDLE;
			endcase
		end
	end

	//=============================================
	// Checks
	a_queue_posts: assert property (@(posedge clk_sys) disable iff (!rstn)
		post && !ev_full |=> ev_valid) else $error("event not queued"); // [RULE23]
	a_fill_null: assert property (@(posedge clk_sys) disable iff (!rstn)
		st_q == S_FILL && idx_q < nr_q |=> pt_we_q && pt_q.value == NULL_POINT) else $error("fill not null"); // [RULE22]
	a_no_excess: assert property (@(posedge clk_sys) disable iff (!rstn)
		pt_we_q |-> pt_q.index < nr_q) else $error("excess point written"); // [RULE3]
	a_set_exclusive: assert property (@(posedge clk_sys) disable iff (!rstn)
		!(set_install_q && set_discard_q)) else $error("install and discard"); // [RULE13]
	a_big_drop: assert property (@(posedge clk_sys) disable iff (!rstn)
		post && post_code == EV_SET_BIG |=> set_discard_q ##1 !set_install_q) else $error("big block kept"); // [RULE15]
	a_echo_drop: assert property (@(posedge clk_sys) disable iff (!rstn)
		post && post_code == EV_ECHO_BIN |=> st_q == S_DROP) else $error("echo block accepted"); // [RULE16]
	a_query_miss: assert property (@(posedge clk_sys) disable iff (!rstn)
		query_req && !src_exists |=> !query_go_q) else $error("query ran on missing source"); // [RULE1]
	a_mem_drop: assert property (@(posedge clk_sys) disable iff (!rstn)
		post && post_code == EV_NO_MEMORY |=> st_q == S_DROP && !alloc_q) else $error("no-memory data kept"); // [RULE5]
	a_pwrup_defaults: assert property (@(posedge clk_sys) disable iff (!rstn)
		post && post_code == EV_CORRUPT |=> load_defaults_q) else $error("defaults not loaded"); // [RULE18]

endmodule // bbt_checker

/* File: logic/bbt_pkg.sv */
// Package: constants, types and event codes for the binary block transfer checker
//=============================================
// Summary of operation
// RULE1: Point readback from a missing stored slot posts event 270, no data.
// RULE2: Point readback from a missing trace posts event 269, no point data.
// RULE3: Binary points beyond the point count are discarded; event 161 posted.
// RULE4: ASCII values beyond the point count are discarded; event 162 posted.
// RULE5: Missing target slot is allocated first; no memory posts 255, drops data.
// RULE6: Binary point checksum mismatch posts warning 552, data still stored.
// RULE7: Early end on the bus mid point block pads nulls, posts 551.
// RULE8: Odd point byte count with good checksum drops last byte, posts 555.
// RULE9: Combined query behaves as preamble query then point query.
// RULE10: Combined query posts 270 or 269 for missing slot or trace.
// RULE11: ASCII settings readback is semicolon-separated strings with no header.
// RULE12: Settings block: percent, count, bytes, checksum as negated byte sum.
// RULE13: Good settings checksum installs block; bad one discards, posts 108.
// RULE14: Early end within a settings block discards it and posts 167.
// RULE15: Settings count above buffer maximum discards block, posts 109.
// RULE16: With echo on at the serial port, binary blocks are discarded, 164.
// RULE17: Settings carry firmware version; mismatch discards and posts 239.
// RULE18: Corruption noticed at power-up loads defaults and posts 658.
// RULE19: The controller returns settings blocks unaltered, with the header.
// RULE20: Settings image excludes waveform records, preambles, interface controls.
// RULE21: Point block count is 16-bit, high byte first, includes checksum.
// RULE22: Too few points fill the record with null -32768, no error.
// RULE23: Every posted event code is queued until the controller reads it; the code drops a post while all 8 queue entries are full.
package bbt_pkg;

	localparam logic [9:0] EV_NO_SLOT    = 10'd270;
	localparam logic [9:0] EV_NO_TRACE   = 10'd269;
	localparam logic [9:0] EV_BIN_EXCESS = 10'd161;
	localparam logic [9:0] EV_ASC_EXCESS = 10'd162;
	localparam logic [9:0] EV_NO_MEMORY  = 10'd255;
	localparam logic [9:0] EV_PT_CSUM    = 10'd552;
	localparam logic [9:0] EV_PT_SHORT   = 10'd551;
	localparam logic [9:0] EV_PT_ODD     = 10'd555;
	localparam logic [9:0] EV_SET_CSUM   = 10'd108;
	localparam logic [9:0] EV_SET_SHORT  = 10'd167;
	localparam logic [9:0] EV_SET_BIG    = 10'd109;
	localparam logic [9:0] EV_ECHO_BIN   = 10'd164;
	localparam logic [9:0] EV_SET_VER    = 10'd239;
	localparam logic [9:0] EV_CORRUPT    = 10'd658;

	localparam logic [7:0]  BLOCK_MARK   = 8'h25;
	localparam logic [15:0] NULL_POINT   = 16'h8000;
	localparam logic [15:0] RST_POINT_COUNT_FIELD    = 16'h0400;
	localparam int          EVQ_DEPTH    = 8;
	localparam logic [15:0] SET_MAX_RST  = 16'h0800;
	localparam logic [7:0]  FW_VER_RST   = 8'h01;

	typedef enum logic [1:0] {BBT_KIND_POINTS, BBT_KIND_SETTINGS, BBT_KIND_ASCII} bbt_kind_t;

	// Received link byte with its end marker and port of arrival
	typedef struct packed {
		logic [7:0] data;
		logic       eoi;
		logic       serial;
	} bbt_byte_t;

	// Point handed to waveform memory
	typedef struct packed {
		logic [15:0] index;
		logic [15:0] value;
	} bbt_point_t;

endpackage : bbt_pkg

/* File: tb/bbt_ctrl_model.sv */
// Controller model: offers queued link bytes to the checker
module bbt_ctrl_model
	import bbt_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rx_ready,
	output logic      rx_valid,
	output bbt_byte_t rx_byte
);
	timeunit 1ns;
	timeprecision 1ns;

	bbt_byte_t q[$];

	initial
	begin
		rx_valid = 1'b0;
		rx_byte  = '0;
	end

	//==============================================
	// Byte offer
	// Blocks leave byte for byte as queued, count high byte first
	// A byte is held until taken; idle data toggles so no stale value looks valid
	always @(posedge clk_sys)
	begin
		if (!rx_valid || rx_ready)
		begin
			if (rx_valid)
				void'(q.pop_front());
			rx_valid <= (q.size() != 0);
			rx_byte  <= (q.size() != 0) ? q[0] : {~rx_byte.data, 1'b0, 1'b0};
		end
	end
endmodule // bbt_ctrl_model

/* File: tb/testbench.sv */
// Testbench: point and settings blocks, queries and resets through the checker
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end

module testbench
	import bbt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam bbt_kind_t KP = BBT_KIND_POINTS;
	localparam bbt_kind_t KS = BBT_KIND_SETTINGS;

	typedef struct {
		bbt_kind_t  k;
		int         nr, np, bad, cut;
		bit         ser, echo, slot, mem;
		logic [9:0] ev;
		int         pts, nul;
	} bbt_row_t;

	logic        clk_sys, rstn, rx_valid, rx_ready, blk_start, echo_on, slot_exists, mem_avail;
	logic        query_req, src_is_slot, src_exists, corrupt_at_pwrup, ev_pop, ev_valid;
	logic        ascii_value, ascii_end;
	logic        pt_we_q, alloc_q, set_install_q, set_discard_q, load_defaults_q, query_go_q, set_byte_we_q;
	logic [15:0] point_count_field, first_v;
	logic [9:0]  ev_code;
	logic [7:0]  set_byte_q;
	bbt_byte_t   rx_byte;
	bbt_kind_t   blk_kind;
	bbt_point_t  pt_q;
	int          err_count, tests_run, n_pt, n_nul, n_alloc, n_inst, n_disc, n_sb, n_go, n_def, j;

	// Small settings limit keeps the oversize block short
	bbt_checker #(.SET_MAX(16'h0010)) bbt_checker_i (
		.clk_sys, .rstn, .rx_valid, .rx_byte, .rx_ready, .blk_start, .blk_kind, .point_count_field,
		.echo_on, .slot_exists, .mem_avail, .alloc_req_ack(1'b0), .query_req, .src_is_slot,
		.src_exists, .corrupt_at_pwrup, .ascii_value, .ascii_end, .pt_q, .pt_we_q,
		.alloc_q, .set_install_q, .set_discard_q, .load_defaults_q, .query_go_q, .set_byte_q,
		.set_byte_we_q, .ev_pop, .ev_code, .ev_valid
	);

	bbt_ctrl_model ctrl_i (.clk_sys, .rx_ready, .rx_valid, .rx_byte);

	bbt_row_t rows[15] = '{
		'{KP, 2, 4, 0, 0, 0, 0, 1, 1, 10'h000, 2, 0},
		'{KP, 2, 4, 1, 0, 0, 0, 1, 1, EV_PT_CSUM, 2, 0},
		'{KP, 1, 4, 0, 0, 0, 0, 1, 1, EV_BIN_EXCESS, 1, 0},
		'{KP, 3, 4, 0, 0, 0, 0, 1, 1, 10'h000, 3, 1},
		'{KP, 1, 3, 0, 0, 0, 0, 1, 1, EV_PT_ODD, 1, 0},
		'{KP, 2, 4, 0, 5, 0, 0, 1, 1, EV_PT_SHORT, 2, 1},
		'{KP, 2, 4, 0, 0, 1, 1, 1, 1, EV_ECHO_BIN, 0, 0},
		'{KP, 2, 4, 0, 0, 0, 0, 0, 0, EV_NO_MEMORY, 0, 0},
		'{KP, 2, 4, 0, 0, 0, 0, 0, 1, 10'h000, 2, 0},
		'{KS, 0, 4, 0, 0, 0, 0, 1, 1, 10'h000, 0, 0},
		'{KS, 0, 4, 1, 0, 0, 0, 1, 1, EV_SET_CSUM, 0, 0},
		'{KS, 0, 4, 2, 0, 0, 0, 1, 1, EV_SET_VER, 0, 0},
		'{KS, 0, 4, 0, 4, 0, 0, 1, 1, EV_SET_SHORT, 0, 0},
		'{KS, 0, 17, 0, 0, 0, 0, 1, 1, EV_SET_BIG, 0, 0},
		'{KS, 0, 4, 0, 0, 1, 1, 1, 1, EV_ECHO_BIN, 0, 0}
	};

	always #5 clk_sys = ~clk_sys;

	//==============================================
	// Output monitor
	always @(posedge clk_sys)
	begin
		if (pt_we_q === 1'b1)
		begin
			n_pt++;
			if (n_pt == 1)
				first_v = pt_q.value;
			if (pt_q.value === NULL_POINT)
				n_nul++;
		end
		n_alloc += int'(alloc_q === 1'b1);
		n_inst  += int'(set_install_q === 1'b1);
		n_disc  += int'(set_discard_q === 1'b1);
		n_sb    += int'(set_byte_we_q === 1'b1);
		n_go    += int'(query_go_q === 1'b1);
		n_def   += int'(load_defaults_q === 1'b1);
	end

	//==============================================
	// Tasks
	task tally_and_finish;
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task pop_ev;
		@(posedge clk_sys);
		ev_pop <= 1'b1;
		@(posedge clk_sys);
		ev_pop <= 1'b0;
		@(negedge clk_sys);
	endtask

	// Builds mark, count, optional version, body and negated byte sum
	task automatic send_block(bbt_row_t r);
		logic [7:0]  b[$];
		logic [15:0] cnt;
		logic [7:0]  s;
		cnt = 16'(r.np + 1 + int'(r.k == KS));
		b = '{BLOCK_MARK, cnt[15:8], cnt[7:0]};
		if (r.k == KS)
			b.push_back(r.bad == 2 ? ~FW_VER_RST : FW_VER_RST);
		for (int i = 0; i < r.np; i++)
			b.push_back(8'h10 + 8'(i));
		s = 8'h00;
		for (int i = 1; i < b.size(); i++)
			s += b[i];
		b.push_back((8'h00 - s) ^ {7'h00, r.bad == 1});
		if (r.cut > 0)
			b = b[0:r.cut-1];
		@(negedge clk_sys);
		for (int i = 0; i < b.size(); i++)
			ctrl_i.q.push_back(bbt_byte_t'{b[i], i == b.size() - 1, r.ser});
	endtask

	// Bounded wait until the model has handed over every byte
	task wait_empty;
		int n;
		for (n = 0; n < 400 && (ctrl_i.q.size() != 0 || rx_valid === 1'b1); n++)
			@(posedge clk_sys);
		if (n == 400)
		begin
			err_count++;
			tally_and_finish();
		end
	endtask

	task automatic run_row(bbt_row_t r);
		@(posedge clk_sys);
		{n_pt, n_nul, n_alloc, n_inst, n_disc, n_sb} = '0;
		blk_kind <= r.k;
		point_count_field <= 16'(r.nr);
		echo_on <= r.echo;
		slot_exists <= r.slot;
		mem_avail <= r.mem;
		blk_start <= 1'b1;
		@(posedge clk_sys);
		blk_start <= 1'b0;
		send_block(r);
		wait_empty();
		repeat (12) @(negedge clk_sys);
		`CHK(ev_valid, r.ev != 10'h000)
		if (r.ev != 10'h000)
		begin
			`CHK(ev_code, r.ev)
			pop_ev();
		end
		`CHK(n_pt, r.pts)
		`CHK(n_nul, r.nul)
		if (r.pts > 0)
			`CHK(first_v, 16'h1011)
		if (r.k == KS)
		begin
			`CHK(n_inst, int'(r.ev == 10'h000))
			`CHK(n_disc, int'(r.ev != 10'h000))
			if (r.ev == 10'h000)
				`CHK(n_sb, r.np + 1)
		end
		else if (r.ev == 10'h000)
			`CHK(n_alloc, int'(!r.slot))
	endtask

	//==============================================
	// Main sequence
	initial
	begin
		clk_sys = 1'b0;
		rstn = 1'b0;
		blk_start = 1'b0;
		blk_kind = KP;
		point_count_field = 16'h0000;
		echo_on = 1'b0;
		slot_exists = 1'b1;
		mem_avail = 1'b1;
		query_req = 1'b0;
		src_is_slot = 1'b0;
		src_exists = 1'b0;
		corrupt_at_pwrup = 1'b0;
		ascii_value = 1'b0;
		ascii_end = 1'b0;
		ev_pop = 1'b0;
		repeat (16) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (2) @(negedge clk_sys);
		`CHK(ev_valid, 1'b0)
		foreach (rows[i])
			run_row(rows[i]);
		// Two ASCII values into a one-point record: the second is surplus
		n_pt = 0;
		@(posedge clk_sys);
		blk_kind <= BBT_KIND_ASCII;
		point_count_field <= 16'h0001;
		blk_start <= 1'b1;
		@(posedge clk_sys);
		blk_start <= 1'b0;
		ascii_value <= 1'b1;
		repeat (2) @(posedge clk_sys);
		ascii_value <= 1'b0;
		ascii_end <= 1'b1;
		@(posedge clk_sys);
		ascii_end <= 1'b0;
		repeat (3) @(negedge clk_sys);
		`CHK(n_pt, 1)
		`CHK(ev_valid, 1'b1)
		`CHK(ev_code, EV_ASC_EXCESS)
		pop_ev();
		// Nine failed queries: the ninth overflows the eight-deep queue
		for (j = 0; j < 9; j++)
		begin
			@(posedge clk_sys);
			src_is_slot <= j[0];
			src_exists <= 1'b0;
			query_req <= 1'b1;
			@(posedge clk_sys);
			query_req <= 1'b0;
		end
		repeat (3) @(negedge clk_sys);
		for (j = 0; j < 8; j++)
		begin
			`CHK(ev_code, j[0] ? EV_NO_SLOT : EV_NO_TRACE)
			pop_ev();
		end
		`CHK(ev_valid, 1'b0)
		n_go = 0;
		@(posedge clk_sys);
		src_is_slot <= 1'b1;
		src_exists <= 1'b1;
		query_req <= 1'b1;
		@(posedge clk_sys);
		query_req <= 1'b0;
		repeat (3) @(negedge clk_sys);
		`CHK(n_go, 1)
		`CHK(ev_valid, 1'b0)
		// Second reset with corrupted settings seen at power-up
		@(posedge clk_sys);
		rstn <= 1'b0;
		corrupt_at_pwrup <= 1'b1;
		n_def = 0;
		repeat (16) @(negedge clk_sys);
		`CHK(ev_valid, 1'b0)
		@(posedge clk_sys);
		rstn <= 1'b1;
		repeat (4) @(negedge clk_sys);
		corrupt_at_pwrup <= 1'b0;
		`CHK(n_def, 1)
		`CHK(ev_code, EV_CORRUPT)
		tally_and_finish();
	end
endmodule // testbench
